// ===== hdl/cms_arith.sv
// cms_arith.sv: unsigned 8x8 multiplier and two's complement negate with flags
// assumes operands are stable flip-flop or memory values on the core clock
`timescale 1ns/10ps
module cms_arith
(
  input  wire logic [7:0]  acc_i,
  input  wire logic [7:0]  opnd_i,
  output logic      [15:0] prod_o,
  output logic      [7:0]  neg_o,
  output logic             neg_c_o,
  output logic             neg_dc_o,
  output logic             neg_z_o,
  output logic             neg_ov_o,
  output logic             neg_n_o
);
  // unsigned product, never overflows 16 bits
  assign prod_o   = {8'h00, acc_i} * {8'h00, opnd_i};

  // negate as 0 - f; carry and digit carry mean no borrow out
  assign neg_o    = ~opnd_i + 8'h01;
  assign neg_c_o  = (opnd_i == 8'h00);
  assign neg_dc_o = (opnd_i[3:0] == 4'h0);
  assign neg_ov_o = (opnd_i == 8'h80);     // only -128 overflows
  assign neg_z_o  = (neg_o == 8'h00);
  assign neg_n_o  = neg_o[7];
endmodule

// ===== hdl/cms_exec_unit.sv
// cms_exec_unit.sv: execute block for multiply, negate, idle, stack and return opcodes
// assumes program and data memory answer combinationally on the same clock
`timescale 1ns/10ps
module cms_exec_unit
  import cms_pkg::*;
#(
  parameter int STACK_DEPTH = `CMS_STACK_DEPTH
)
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] instr_i,
  input  wire logic [7:0]  mem_rdata_i,
  input  wire logic        ext_set_en_i,
  input  wire logic [11:0] fsr2_i,
  input  wire logic        int_entry_i,
  input  wire logic        int_high_i,
  output logic      [20:0] pc_o,
  output logic      [1:0]  phase_o,
  output logic      [11:0] mem_addr_o,
  output logic      [7:0]  mem_wdata_o,
  output logic             mem_we_o,
  output logic      [7:0]  acc_o,
  output logic      [7:0]  status_o,
  output logic      [7:0]  bsr_o,
  output logic      [7:0]  prod_hi_o,
  output logic      [7:0]  prod_lo_o,
  output logic             high_priority_int_enable_o,
  output logic             low_priority_int_enable_o,
  output logic      [7:0]  pc_upper_latch_high_o,
  output logic      [7:0]  pc_top_latch_o,
  output logic      [20:0] tos_o,
  output logic      [7:0]  stack_level_o,
  output logic             soft_reset_o
);
  localparam int PTR_W = $clog2(STACK_DEPTH + 1);

  typedef struct packed {
    cms_phase_t                   phase;
    logic [15:0]                  ir;
    logic                         flush;
    logic [20:0]                  pc;
    logic [7:0]                   acc;
    logic [7:0]                   status;
    logic [7:0]                   bank_select_reg;
    logic [7:0]                   prod_hi;
    logic [7:0]                   prod_lo;
    logic [7:0]                   acc_sh;
    logic [7:0]                   status_sh;
    logic [7:0]                   bsr_sh;
    logic                         high_priority_int_enable;
    logic                         low_priority_int_enable;
    logic [7:0]                   pc_upper_latch_high;
    logic [7:0]                   pc_top_latch;
    logic [STACK_DEPTH-1:0][20:0] stk;
    logic [PTR_W-1:0]             ptr;
    logic [7:0]                   wdata;
    logic                         we;
    logic                         soft_pulse;
  } cms_state_t;

  cms_state_t  st_ff;
  cms_state_t  nxt_st;
  logic        is_mul;
  logic        is_neg;
  logic        is_pop;
  logic        is_push;
  logic        is_relative_call;
  logic        is_reset;
  logic        is_interrupt_return;
  logic        is_literal_return;
  logic        is_idle;
  logic        two_cycle;
  logic        stk_full;
  logic        stk_empty;
  logic [7:0]  fld;
  logic [20:0] stack_top;
  logic [20:0] ret_addr;
  logic [20:0] relative_call_off;
  logic [15:0] prod;
  logic [7:0]  neg_val;
  logic        neg_c;
  logic        neg_dc;
  logic        neg_z;
  logic        neg_ov;
  logic        neg_n;

  // power-on and software reset state
  function automatic cms_state_t reset_state();
    cms_state_t s;
    s            = '0;
    s.phase      = PH_Q1;
    s.ir         = `CMS_RST_IR;
    s.pc         = `CMS_RST_PC;
    s.acc        = `CMS_RST_BYTE;
    s.status     = `CMS_RST_BYTE;
    s.bank_select_reg        = `CMS_RST_BYTE;
    s.prod_hi    = `CMS_RST_BYTE;
    s.prod_lo    = `CMS_RST_BYTE;
    s.acc_sh     = `CMS_RST_BYTE;
    s.status_sh  = `CMS_RST_BYTE;
    s.bsr_sh     = `CMS_RST_BYTE;
    s.pc_upper_latch_high     = `CMS_RST_BYTE;
    s.pc_top_latch     = `CMS_RST_BYTE;
    s.wdata      = `CMS_RST_BYTE;
    return s;
  endfunction

  // opcode decode of the latched instruction word
  assign fld       = st_ff.ir[7:0];
  assign is_mul    = (st_ff.ir[15:9] == `CMS_OP_MUL_HI);
  assign is_neg    = (st_ff.ir[15:9] == `CMS_OP_NEG_HI);
  assign is_pop    = (st_ff.ir == `CMS_OP_POP);
  assign is_push   = (st_ff.ir == `CMS_OP_PUSH);
  assign is_relative_call  = (st_ff.ir[15:11] == `CMS_OP_RELATIVE_CALL_HI);
  assign is_reset  = (st_ff.ir == `CMS_OP_RESET);
  assign is_interrupt_return = (st_ff.ir[15:1] == `CMS_OP_INTERRUPT_RETURN_HI);
  assign is_literal_return  = (st_ff.ir[15:8] == `CMS_OP_LITERAL_RETURN_HI);
  assign is_idle   = (st_ff.ir == `CMS_OP_IDLE) || (st_ff.ir[15:12] == `CMS_OP_IDLE_TOP);
  assign two_cycle = is_relative_call || is_interrupt_return || is_literal_return;

  // return stack view and address arithmetic
  assign stk_full  = (st_ff.ptr == PTR_W'(STACK_DEPTH));
  assign stk_empty = (st_ff.ptr == '0);
  assign stack_top       = stk_empty ? `CMS_RST_PC : st_ff.stk[st_ff.ptr - PTR_W'(1)];
  assign ret_addr  = st_ff.pc + `CMS_PC_STEP;
  assign relative_call_off = {{9{st_ff.ir[10]}}, st_ff.ir[10:0], 1'b0};

  // file address: bank register, indexed offset or access bank
  always_comb
  begin
    if (st_ff.ir[`CMS_BANK_BIT])
      mem_addr_o = {st_ff.bank_select_reg[3:0], fld};
    else if (ext_set_en_i && (fld <= `CMS_INDEXED_MAX))
      mem_addr_o = fsr2_i + {4'h0, fld};
    else if (fld < `CMS_ACCESS_SPLIT)
      mem_addr_o = {`CMS_ACCESS_LOW, fld};
    else
      mem_addr_o = {`CMS_ACCESS_HIGH, fld};
  end

  cms_arith u_arith
  (
    .acc_i    (st_ff.acc),
    .opnd_i   (mem_rdata_i),
    .prod_o   (prod),
    .neg_o    (neg_val),
    .neg_c_o  (neg_c),
    .neg_dc_o (neg_dc),
    .neg_z_o  (neg_z),
    .neg_ov_o (neg_ov),
    .neg_n_o  (neg_n)
  );

  // next state: one phase per clock, four per instruction cycle
  always_comb
  begin
    nxt_st            = st_ff;
    nxt_st.soft_pulse = 1'b0;
    case (st_ff.phase)
      PH_Q1:
      begin
        nxt_st.phase = PH_Q2;
        nxt_st.ir    = st_ff.flush ? `CMS_OP_IDLE : instr_i;
      end
      PH_Q2:
      begin
        nxt_st.phase = PH_Q3;
        if (is_reset)
        begin
          nxt_st            = reset_state();
          nxt_st.soft_pulse = 1'b1;
        end
      end
      PH_Q3:
      begin
        nxt_st.phase = PH_Q4;
        if (is_mul)
        begin
          nxt_st.prod_hi = prod[15:8];
          nxt_st.prod_lo = prod[7:0];
        end
        if (is_neg)
        begin
          nxt_st.wdata              = neg_val;
          nxt_st.we                 = 1'b1;
          nxt_st.status[`CMS_ST_C]  = neg_c;
          nxt_st.status[`CMS_ST_DC] = neg_dc;
          nxt_st.status[`CMS_ST_Z]  = neg_z;
          nxt_st.status[`CMS_ST_OV] = neg_ov;
          nxt_st.status[`CMS_ST_N]  = neg_n;
        end
      end
      PH_Q4:
      begin
        nxt_st.phase = PH_Q1;
        nxt_st.we    = 1'b0;
        if (st_ff.flush)
          nxt_st.flush = 1'b0;
        else
        begin
          nxt_st.pc = ret_addr;
          if (is_pop && !stk_empty)
            nxt_st.ptr = st_ff.ptr - PTR_W'(1);
          if ((is_push || is_relative_call) && !stk_full)
          begin
            nxt_st.stk[st_ff.ptr] = ret_addr;
            nxt_st.ptr            = st_ff.ptr + PTR_W'(1);
          end
          if (is_relative_call)
            nxt_st.pc = ret_addr + relative_call_off;
          if (is_interrupt_return || is_literal_return)
          begin
            nxt_st.pc = stack_top;
            if (!stk_empty)
              nxt_st.ptr = st_ff.ptr - PTR_W'(1);
          end
          if (is_interrupt_return)
          begin
            if (!st_ff.high_priority_int_enable)
              nxt_st.high_priority_int_enable = 1'b1;
            else
              nxt_st.low_priority_int_enable = 1'b1;
            if (st_ff.ir[`CMS_SHADOW_BIT])
            begin
              nxt_st.acc    = st_ff.acc_sh;
              nxt_st.status = st_ff.status_sh;
              nxt_st.bank_select_reg    = st_ff.bsr_sh;
            end
          end
          if (is_literal_return)
            nxt_st.acc = fld;
          if (two_cycle)
            nxt_st.flush = 1'b1;
        end
      end
      default:
        nxt_st = reset_state();
    endcase
    // interrupt entry: save shadows and drop the matching enable
    if (int_entry_i && !nxt_st.soft_pulse)
    begin
      nxt_st.acc_sh    = st_ff.acc;
      nxt_st.status_sh = st_ff.status;
      nxt_st.bsr_sh    = st_ff.bank_select_reg;
      if (int_high_i)
        nxt_st.high_priority_int_enable = 1'b0;
      else
        nxt_st.low_priority_int_enable = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      st_ff <= reset_state();
    else
      st_ff <= nxt_st;
  end

  // outputs straight from the state register
  assign pc_o          = st_ff.pc;
  assign phase_o       = st_ff.phase;
  assign mem_wdata_o   = st_ff.wdata;
  assign mem_we_o      = st_ff.we;
  assign acc_o         = st_ff.acc;
  assign status_o      = st_ff.status;
  assign bsr_o         = st_ff.bank_select_reg;
  assign prod_hi_o     = st_ff.prod_hi;
  assign prod_lo_o     = st_ff.prod_lo;
  assign high_priority_int_enable_o        = st_ff.high_priority_int_enable;
  assign low_priority_int_enable_o        = st_ff.low_priority_int_enable;
  assign pc_upper_latch_high_o      = st_ff.pc_upper_latch_high;
  assign pc_top_latch_o      = st_ff.pc_top_latch;
  assign tos_o         = stack_top;
  assign stack_level_o = 8'(st_ff.ptr);
  assign soft_reset_o  = st_ff.soft_pulse;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // sequences of the relative call: one-cycle commit and multi-step refill bubble
  sequence s_relative_call_commit;
    (st_ff.phase == PH_Q4) && is_relative_call && !st_ff.flush;
  endsequence

  sequence s_bubble;
    st_ff.flush [*4] ##1 !st_ff.flush;
  endsequence

  mul_product_a: assert property ((st_ff.phase == PH_Q3) && is_mul |=>
    ({st_ff.prod_hi, st_ff.prod_lo} == 16'({8'h00, $past(st_ff.acc)} * {8'h00, $past(mem_rdata_i)})))
    else $error("product pair wrong after multiply");

  mul_keeps_flags_a: assert property ((st_ff.phase == PH_Q3) && is_mul |=>
    $stable(st_ff.acc) && $stable(st_ff.status) && !st_ff.we)
    else $error("multiply changed accumulator, flags or file");

  bank_addr_a: assert property ((st_ff.phase == PH_Q3) && st_ff.ir[`CMS_BANK_BIT] |->
    (mem_addr_o == {st_ff.bank_select_reg[3:0], fld}))
    else $error("bank register not used for file address");

  indexed_addr_a: assert property (!st_ff.ir[`CMS_BANK_BIT] && ext_set_en_i && (fld <= `CMS_INDEXED_MAX) |->
    (mem_addr_o == 12'(fsr2_i + {4'h0, fld})))
    else $error("indexed offset address wrong");

  negate_write_a: assert property ((st_ff.phase == PH_Q3) && is_neg |=>
    st_ff.we && (st_ff.wdata == 8'(8'h00 - $past(mem_rdata_i)))
    && (st_ff.status[`CMS_ST_Z] == (st_ff.wdata == 8'h00))
    && (st_ff.status[`CMS_ST_C] == ($past(mem_rdata_i) == 8'h00)))
    else $error("negate result or flags wrong");

  pop_level_a: assert property ((st_ff.phase == PH_Q4) && is_pop && !stk_empty |=>
    (st_ff.ptr == $past(st_ff.ptr) - PTR_W'(1)) && (st_ff.pc == $past(ret_addr)))
    else $error("pop did not drop one level or moved the counter");

  push_top_a: assert property ((st_ff.phase == PH_Q4) && is_push && !stk_full |=>
    (stack_top == $past(ret_addr)) && (st_ff.ptr == $past(st_ff.ptr) + PTR_W'(1)))
    else $error("push top of stack wrong");

  relative_call_push_a: assert property (s_relative_call_commit ##0 !stk_full |=> (stack_top == $past(ret_addr)))
    else $error("relative call return address not pushed");

  relative_call_target_a: assert property (s_relative_call_commit |=>
    (st_ff.pc == 21'($past(ret_addr) + $past(relative_call_off))))
    else $error("relative call target wrong");

  relative_call_bubble_a: assert property (s_relative_call_commit |=> s_bubble)
    else $error("relative call second cycle not idle");

  soft_reset_a: assert property ((st_ff.phase == PH_Q2) && is_reset |=>
    soft_reset_o && (st_ff.pc == `CMS_RST_PC) && stk_empty && (st_ff.acc == `CMS_RST_BYTE))
    else $error("software reset did not restore state");

  interrupt_return_pop_a: assert property ((st_ff.phase == PH_Q4) && is_interrupt_return && !st_ff.flush && !int_entry_i |=>
    (st_ff.pc == $past(stack_top)) && (st_ff.high_priority_int_enable || st_ff.low_priority_int_enable))
    else $error("interrupt return pop or enable wrong");

  shadow_copy_a: assert property ((st_ff.phase == PH_Q4) && is_interrupt_return && st_ff.ir[`CMS_SHADOW_BIT]
    && !st_ff.flush |=> (st_ff.acc == $past(st_ff.acc_sh)) && (st_ff.bank_select_reg == $past(st_ff.bsr_sh)))
    else $error("shadow registers not restored");

  literal_return_load_a: assert property ((st_ff.phase == PH_Q4) && is_literal_return && !st_ff.flush |=>
    (st_ff.acc == $past(fld)) && (st_ff.pc == $past(stack_top)))
    else $error("literal return wrong");

  latch_hold_a: assert property ((st_ff.phase == PH_Q4) && (is_interrupt_return || is_literal_return) |=>
    $stable(st_ff.pc_upper_latch_high) && $stable(st_ff.pc_top_latch))
    else $error("return touched counter latches");

  idle_quiet_a: assert property ((st_ff.phase == PH_Q2) && is_idle |=>
    ($stable(st_ff.acc) && $stable(st_ff.ptr) && !st_ff.we) [*3])
    else $error("idle instruction changed state");

  bubble_ir_a: assert property ((st_ff.phase == PH_Q4) && two_cycle && !st_ff.flush |->
    ##2 (st_ff.ir == `CMS_OP_IDLE) && st_ff.flush)
    else $error("second cycle did not execute idle");
endmodule

// ===== hdl/cms_pkg.sv
// cms_pkg.sv: types shared by the execute block
// assumes cms_regs.svh is on the include path
package cms_pkg;
  `include "cms_regs.svh"

  // the four phases of one instruction cycle
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} cms_phase_t;
endpackage

// ===== hdl/cms_regs.svh
// cms_regs.svh: opcodes, field positions, reset values and steps of the execute block
// assumes it is included by bare name from the package and the design files
`ifndef CMS_REGS_SVH
`define CMS_REGS_SVH

// opcode patterns, compared against the top bits or, for pop, push, reset and idle, the whole instruction word
`define CMS_OP_MUL_HI     7'h01
`define CMS_OP_NEG_HI     7'h36
`define CMS_OP_RELATIVE_CALL_HI   5'h1B
`define CMS_OP_LITERAL_RETURN_HI   8'h0C
`define CMS_OP_INTERRUPT_RETURN_HI  15'h0008
`define CMS_OP_POP        16'h0006
`define CMS_OP_PUSH       16'h0005
`define CMS_OP_RESET      16'h0F0F
`define CMS_OP_IDLE       16'h0000
`define CMS_OP_IDLE_TOP   4'hF

// instruction field positions
`define CMS_BANK_BIT      8
`define CMS_SHADOW_BIT    0

// file addressing limits
`define CMS_INDEXED_MAX   8'h5F
`define CMS_ACCESS_SPLIT  8'h80
`define CMS_ACCESS_LOW    4'h0
`define CMS_ACCESS_HIGH   4'hF

// status flag positions
`define CMS_ST_C          0
`define CMS_ST_DC         1
`define CMS_ST_Z          2
`define CMS_ST_OV         3
`define CMS_ST_N          4

// reset values
`define CMS_RST_PC        21'h000000
`define CMS_RST_BYTE      8'h00
`define CMS_RST_IR        16'h0000

// program counter step of one instruction word
`define CMS_PC_STEP       21'h000002

// default return stack depth
`define CMS_STACK_DEPTH   31

`endif

// ===== sim/tb.sv
// tb.sv: self-checking bench for the multiply, negate, stack and return execute block
// assumes the cms package is compiled first; the bench plays program and data memory itself
`timescale 1ns/10ps
module tb;
  import cms_pkg::*;
  logic        clock_i      = 1'b0;
  logic        rst_i        = 1'b1;
  logic [15:0] instr_i      = 16'h0000;
  logic [7:0]  mem_rdata_i  = 8'h00;
  logic        ext_set_en_i = 1'b0;
  logic [11:0] fsr2_i       = 12'h300;
  logic        int_entry_i  = 1'b0;
  logic        int_high_i   = 1'b1;
  logic [20:0] pc_o, tos_o;
  logic [1:0]  phase_o;
  logic [11:0] mem_addr_o, q2_addr;
  logic [7:0]  mem_wdata_o, acc_o, status_o, bsr_o, prod_hi_o, prod_lo_o, pc_upper_latch_high_o, pc_top_latch_o, stack_level_o;
  logic        mem_we_o, high_priority_int_enable_o, low_priority_int_enable_o, soft_reset_o, q4_we, e_gh, e_gl;
  logic [7:0]  q4_wd, e_acc, e_st, e_bsr;
  logic [20:0] e_pc;
  logic [15:0] e_prod;
  logic [23:0] e_sh;
  logic [20:0] stk[$];
  int          num_errors   = 0;
  int          checks       = 0;

  cms_exec_unit #(.STACK_DEPTH(31)) cms_exec_unit_inst (.clock_i(clock_i), .rst_i(rst_i), .instr_i(instr_i),
    .mem_rdata_i(mem_rdata_i), .ext_set_en_i(ext_set_en_i), .fsr2_i(fsr2_i), .int_entry_i(int_entry_i),
    .int_high_i(int_high_i), .pc_o(pc_o), .phase_o(phase_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_we_o(mem_we_o), .acc_o(acc_o), .status_o(status_o), .bsr_o(bsr_o), .prod_hi_o(prod_hi_o),
    .prod_lo_o(prod_lo_o), .high_priority_int_enable_o(high_priority_int_enable_o), .low_priority_int_enable_o(low_priority_int_enable_o), .pc_upper_latch_high_o(pc_upper_latch_high_o), .pc_top_latch_o(pc_top_latch_o),
    .tos_o(tos_o), .stack_level_o(stack_level_o), .soft_reset_o(soft_reset_o));

  // core clock, 50 ns period
  always #25 clock_i = ~clock_i;

  // verdict and end of run
  task automatic results();
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one comparison, reported at once when it differs
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // bounded wait for the first phase of an instruction cycle
  task automatic wait_q1();
    int n;
    n = 0;
    while (phase_o !== 2'h0 && n < 8)
    begin
      @(negedge clock_i);
      n++;
    end
    if (phase_o !== 2'h0)
    begin
      num_errors++;
      results();
    end
  endtask

  // counter, stack, accumulator, status, bank, enables, latches and product against the bench's own model
  task automatic state_chk();
    chk("pc", pc_o, e_pc);
    chk("level", stack_level_o, stk.size());
    chk("tos", tos_o, (stk.size() > 0) ? stk[0] : 21'h0);
    chk("acc", acc_o, e_acc);
    chk("status", status_o, e_st);
    chk("bsr", bsr_o, e_bsr);
    chk("gie", {high_priority_int_enable_o, low_priority_int_enable_o}, {e_gh, e_gl});
    chk("latches", {pc_upper_latch_high_o, pc_top_latch_o}, 16'h0000);
    chk("product", {prod_hi_o, prod_lo_o}, e_prod);
  endtask

  // one instruction cycle: fetch in Q1, capture address in Q2 and write side in Q4
  task automatic issue(input logic [15:0] w, input logic [7:0] rd);
    wait_q1();
    state_chk();
    instr_i = w;
    mem_rdata_i = rd;
    @(negedge clock_i);
    q2_addr = mem_addr_o;
    instr_i = 16'h0000;
    repeat (2) @(negedge clock_i);
    q4_we = mem_we_o;
    q4_wd = mem_wdata_o;
    @(negedge clock_i);
    chk("we_low", mem_we_o, 1'b0);
    e_pc = e_pc + 21'h000002;
  endtask

  // refill cycle after a jump; a push offered here must be ignored
  task automatic bubble();
    instr_i = 16'h0005;
    repeat (4) @(negedge clock_i);
    instr_i = 16'h0000;
  endtask

  task automatic push();
    issue(16'h0005, 8'h00);
    stk.push_front(e_pc);
  endtask

  task automatic literal_return(input logic [7:0] k);
    issue({8'h0C, k}, 8'h00);
    e_acc = k;
    e_pc = (stk.size() > 0) ? stk.pop_front() : 21'h0;
    bubble();
  endtask

  task automatic t_reset();
    state_chk();
    chk("phase", phase_o, 2'h0);
    chk("soft_pulse", soft_reset_o, 1'b0);
  endtask

  // push twice then pop: the older entry returns to the top
  task automatic t_stack();
    push();
    push();
    issue(16'h0006, 8'h00);
    void'(stk.pop_front());
    wait_q1();
    state_chk();
  endtask

  // rows: extended, bank bit, file, expected address, file value
  task automatic t_mul();
    logic [29:0] rows [5] = '{{2'b00, 8'h20, 12'h020, 8'hB5}, {2'b00, 8'h90, 12'hF90, 8'h00},
                              {2'b01, 8'h90, 12'h090, 8'hFF}, {2'b10, 8'h5F, 12'h35F, 8'h01},
                              {2'b10, 8'h60, 12'h060, 8'h80}};
    literal_return(8'hC4);
    foreach (rows[i])
    begin
      ext_set_en_i = rows[i][29];
      issue({7'h01, rows[i][28:20]}, rows[i][7:0]);
      e_prod = e_acc * rows[i][7:0];
      chk("mul_addr", q2_addr, rows[i][19:8]);
      chk("mul_we", q4_we, 1'b0);
    end
    ext_set_en_i = 1'b0;
    wait_q1();
    state_chk();
    chk("mul_example", {prod_hi_o, prod_lo_o}, 16'h6200);
  endtask

  // rows: file value, negated value, status C0 DC1 Z2 OV3 N4
  task automatic t_neg();
    logic [23:0] rows [4] = '{24'h3AC610, 24'h000007, 24'h80801A, 24'hFF0100};
    foreach (rows[i])
    begin
      issue(16'h6C10, rows[i][23:16]);
      e_st = rows[i][7:0];
      chk("neg_we", q4_we, 1'b1);
      chk("neg_data", q4_wd, rows[i][15:8]);
      chk("neg_addr", q2_addr, 12'h010);
    end
    wait_q1();
    state_chk();
  endtask

  // both ends of the offset range
  task automatic t_relative_call();
    logic [10:0] n [2] = '{11'h3FF, 11'h400};
    foreach (n[i])
    begin
      issue({5'h1B, n[i]}, 8'h00);
      stk.push_front(e_pc);
      e_pc = e_pc + {{9{n[i][10]}}, n[i], 1'b0};
      bubble();
    end
    wait_q1();
    state_chk();
  endtask

  // shadow restore on, then off; enables set high priority first, then low
  task automatic t_ret();
    push();
    literal_return(8'h5A);
    issue(16'h6C10, 8'h00);
    e_st = 8'h07;
    wait_q1();
    int_entry_i = 1'b1;
    @(negedge clock_i);
    int_entry_i = 1'b0;
    e_pc = e_pc + 21'h000002;
    e_sh = {e_acc, e_st, e_bsr};
    e_gh = 1'b0;
    push();
    literal_return(8'h11);
    issue(16'h6C10, 8'h3A);
    e_st = 8'h10;
    push();
    issue(16'h0011, 8'h00);
    e_pc = stk.pop_front();
    {e_acc, e_st, e_bsr} = e_sh;
    e_gh = 1'b1;
    bubble();
    push();
    issue(16'h0010, 8'h00);
    e_pc = stk.pop_front();
    e_gl = 1'b1;
    bubble();
    wait_q1();
    state_chk();
  endtask

  // both idle encodings leave everything but the counter alone
  task automatic t_idle();
    issue(16'h0000, 8'h55);
    chk("idle_we", q4_we, 1'b0);
    issue(16'hF123, 8'h55);
    chk("idle_top_we", q4_we, 1'b0);
    wait_q1();
    state_chk();
  endtask

  // software reset from a busy state returns the power-on state
  task automatic t_sreset();
    int n;
    push();
    wait_q1();
    instr_i = 16'h0F0F;
    @(negedge clock_i);
    instr_i = 16'h0000;
    n = 0;
    while (soft_reset_o !== 1'b1 && n < 8)
    begin
      @(negedge clock_i);
      n++;
    end
    chk("soft_pulse", soft_reset_o, 1'b1);
    e_pc = 21'h0;
    {e_acc, e_st, e_bsr, e_gh, e_gl, e_prod} = '0;
    stk.delete();
    wait_q1();
    state_chk();
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    e_pc = 21'h0;
    {e_acc, e_st, e_bsr, e_gh, e_gl, e_prod, e_sh} = '0;
    repeat (16) @(negedge clock_i);
    rst_i = 1'b0;
    t_reset();
    t_stack();
    t_mul();
    t_neg();
    t_relative_call();
    t_ret();
    t_idle();
    t_sreset();
    results();
  end
endmodule
